// *** ort_pkg.sv ***
package ort_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ORT_OFS_OPERATION = 8'h00;
  localparam logic [7:0] ORT_OFS_VOUT_CMD = 8'h04;
  localparam logic [7:0] ORT_OFS_MARGIN_HI = 8'h08;
  localparam logic [7:0] ORT_OFS_MARGIN_LO = 8'h0C;
  localparam logic [7:0] ORT_OFS_TRANS_RATE = 8'h10;
  localparam logic [7:0] ORT_OFS_TRACK_CFG = 8'h14;
  localparam logic [7:0] ORT_OFS_STATUS = 8'h18;
  localparam logic [7:0] ORT_OFS_NOMINAL = 8'h1C;

  // OPERATION fields: margin select in [1:0]
  localparam int ORT_OP_MARGIN_LSB = 0;
  localparam logic [1:0] ORT_MARGIN_NONE = 2'h0;
  localparam logic [1:0] ORT_MARGIN_LOW = 2'h1;
  localparam logic [1:0] ORT_MARGIN_HIGH = 2'h2;

  // VOUT_COMMAND: value in [15:0], source select in bit 16 (1 = command, 0 = strap)
  localparam int ORT_VCMD_SRC_BIT = 16;

  // TRACK_CONFIG fields
  localparam int ORT_TRK_EN_BIT = 0;
  localparam int ORT_TRK_CH_LSB = 1;
  localparam int ORT_TRK_MODE_BIT = 3;
  localparam int ORT_TRK_RATIO_LSB = 8;
  localparam logic [1:0] ORT_TRK_CH0 = 2'h0;
  localparam logic [1:0] ORT_TRK_CH1 = 2'h1;
  localparam logic [1:0] ORT_TRK_DUAL = 2'h2;

  // Reset values
  localparam logic [1:0] ORT_RST_MARGIN = 2'h0;
  localparam logic [15:0] ORT_RST_VOUT_CMD = 16'h0000;
  localparam logic [15:0] ORT_RST_RATE = 16'h0001;
  localparam logic [7:0] ORT_RST_RATIO = 8'h80;
  localparam int ORT_RATIO_SHIFT = 8;

  // Margin and ceiling ratios, numerator over denominator
  localparam int ORT_DEF_HI_NUM = 21;
  localparam int ORT_DEF_LO_NUM = 19;
  localparam int ORT_DEF_DEN = 20;
  localparam int ORT_CEIL_NUM = 11;
  localparam int ORT_CEIL_DEN = 10;

  // Setpoint update period
  localparam int ORT_CLK_PERIOD_NS = 10;
  localparam int ORT_UPDATE_PERIOD_NS = 1000;
  localparam int ORT_UPDATE_CYCLES = (ORT_UPDATE_PERIOD_NS + ORT_CLK_PERIOD_NS - 1) / ORT_CLK_PERIOD_NS;
endpackage

// *** ort_ramp.sv ***
module ort_ramp #(
  parameter int V_W = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  ort_ramp_if.ramp rif
);
  logic [V_W-1:0] value_reg;
  logic [V_W-1:0] value_next;
  logic [V_W-1:0] diff;

  // Step toward the target by at most one increment per tick, never past it
  always_comb begin
    value_next = value_reg;
    diff = '0;
    if (rif.tick) begin
      if (value_reg < rif.target) begin
        diff = rif.target - value_reg;
        value_next = (diff < rif.step) ? rif.target : value_reg + rif.step;
      end else if (value_reg > rif.target) begin
        diff = value_reg - rif.target;
        value_next = (diff < rif.step) ? rif.target : value_reg - rif.step;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      value_reg <= '0;
    end else begin
      value_reg <= value_next;
    end
  end

  assign rif.value = value_reg;
  assign rif.busy = (value_reg != rif.target);
endmodule

// *** ort_ramp_if.sv ***
interface ort_ramp_if #(parameter int V_W = 16);
  logic [V_W-1:0] target;
  logic [V_W-1:0] step;
  logic tick;
  logic [V_W-1:0] value;
  logic busy;
  modport ctrl(output target, output step, output tick, input value, input busy);
  modport ramp(input target, input step, input tick, output value, output busy);
endinterface

// *** ort_ref_ctrl.sv ***
// Our own choices: the Wishbone register port and the register addresses.
module ort_ref_ctrl import ort_pkg::*; #(
  parameter int V_W = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [V_W-1:0] i_tracking_reference_pin,
  input wire logic [V_W-1:0] i_setpoint_strap_pin,
  output logic [V_W-1:0] o_ref_ch0,
  output logic [V_W-1:0] o_ref_ch1,
  output logic o_tracking_active,
  output logic o_ignore_ton_timing,
  output logic o_prebias_unprotected
);
  localparam int EW = V_W + 6;

  if (V_W < 8 || V_W > 16) begin : g_chk
    $error("ort_ref_ctrl: V_W must be 8 to 16");
  end

  // Register state
  logic [1:0] margin_reg, margin_next;
  logic [V_W-1:0] vcmd_reg, vcmd_next;
  logic vsrc_reg, vsrc_next;
  logic [V_W-1:0] mhi_reg, mhi_next;
  logic [V_W-1:0] mlo_reg, mlo_next;
  logic hi_user_reg, hi_user_next;
  logic lo_user_reg, lo_user_next;
  logic [V_W-1:0] rate_reg, rate_next;
  logic trk_en_reg, trk_en_next;
  logic [1:0] trk_ch_reg, trk_ch_next;
  logic trk_ratio_mode_reg, trk_ratio_mode_next;
  logic [7:0] ratio_reg, ratio_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;

  // Pin synchronisers and accepted values
  logic [V_W-1:0] trk_s1_reg, trk_s2_reg, trk_s3_reg, trk_val_reg, trk_val_next;
  logic [V_W-1:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_val_reg, strap_val_next;

  // Update tick and outputs
  logic [$clog2(ORT_UPDATE_CYCLES)-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;
  logic [V_W-1:0] ref0_reg, ref0_next, ref1_reg, ref1_next;
  logic trk_act_reg, trk_act_next;
  logic prebias_reg, prebias_next;

  // Derived setpoint values
  logic [V_W-1:0] nominal, ceiling, hi_eff, lo_eff, target, trk_ref, wval;
  logic [EW-1:0] ceil_w, hi_def_w, lo_def_w, ratio_w;
  logic [V_W+7:0] ratio_prod;
  logic [31:0] wdat;
  logic wr, rd;

  ort_ramp_if #(.V_W(V_W)) rif ();

  ort_ramp #(.V_W(V_W)) u_ramp (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .rif(rif)
  );

  // Merge write data into a register under byte enables
  function automatic logic [31:0] ort_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Nominal, default margins and the hard ceiling
  always_comb begin
    nominal = vsrc_reg ? vcmd_reg : strap_val_reg;
    ceil_w = EW'(({6'h00, nominal} * EW'(ORT_CEIL_NUM)) / EW'(ORT_CEIL_DEN));
    hi_def_w = EW'(({6'h00, nominal} * EW'(ORT_DEF_HI_NUM)) / EW'(ORT_DEF_DEN));
    lo_def_w = EW'(({6'h00, nominal} * EW'(ORT_DEF_LO_NUM)) / EW'(ORT_DEF_DEN));
    // Saturate at full scale so the ceiling never wraps
    ceiling = (ceil_w[EW-1:V_W] != '0) ? {V_W{1'b1}} : ceil_w[V_W-1:0];
    hi_eff = hi_user_reg ? mhi_reg : hi_def_w[V_W-1:0];
    lo_eff = lo_user_reg ? mlo_reg : lo_def_w[V_W-1:0];
    // Limits stay relative to today's nominal, so clamp again on use
    if (hi_eff > ceiling) begin
      hi_eff = ceiling;
    end
    if (lo_eff > ceiling) begin
      lo_eff = ceiling;
    end
    case (margin_reg)
      ORT_MARGIN_HIGH: target = hi_eff;
      ORT_MARGIN_LOW: target = lo_eff;
      default: target = (nominal > ceiling) ? ceiling : nominal;
    endcase
  end

  // Tracking reference: coincident clips at the target, ratiometric scales first
  always_comb begin
    // Full-width product: a high pin value times a large ratio must not wrap
    ratio_prod = {8'h00, trk_val_reg} * {{V_W{1'b0}}, ratio_reg};
    ratio_w = EW'(ratio_prod >> ORT_RATIO_SHIFT);
    if (trk_ratio_mode_reg) begin
      trk_ref = (ratio_w > EW'(target)) ? target : ratio_w[V_W-1:0];
    end else begin
      trk_ref = (trk_val_reg > target) ? target : trk_val_reg;
    end
  end

  // Setpoint ramp drive
  always_comb begin
    rif.target = target;
    rif.step = (rate_reg == '0) ? V_W'(1) : rate_reg;
    rif.tick = tick_reg;
  end

  // Wishbone decode; answer in the cycle after the strobe, every address acks
  always_comb begin
    wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_reg;
    rd = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_reg;
    ack_next = i_wb_cyc && i_wb_stb && !ack_reg;
    wdat = 32'h00000000;
    wval = '0;
    margin_next = margin_reg;
    vcmd_next = vcmd_reg;
    vsrc_next = vsrc_reg;
    mhi_next = mhi_reg;
    mlo_next = mlo_reg;
    hi_user_next = hi_user_reg;
    lo_user_next = lo_user_reg;
    rate_next = rate_reg;
    trk_en_next = trk_en_reg;
    trk_ch_next = trk_ch_reg;
    trk_ratio_mode_next = trk_ratio_mode_reg;
    ratio_next = ratio_reg;
    rdat_next = rdat_reg;
    if (wr) begin
      case (i_wb_adr)
        ORT_OFS_OPERATION: begin
          wdat = ort_merge({30'h00000000, margin_reg}, i_wb_dat, i_wb_sel);
          margin_next = wdat[ORT_OP_MARGIN_LSB +: 2];
        end
        ORT_OFS_VOUT_CMD: begin
          wdat = ort_merge({15'h0000, vsrc_reg, 16'(vcmd_reg)}, i_wb_dat, i_wb_sel);
          vcmd_next = wdat[V_W-1:0];
          vsrc_next = wdat[ORT_VCMD_SRC_BIT];
        end
        ORT_OFS_MARGIN_HI: begin
          wdat = ort_merge({16'h0000, 16'(hi_eff)}, i_wb_dat, i_wb_sel);
          wval = wdat[V_W-1:0];
          mhi_next = (wdat[31:V_W] != '0 || wval > ceiling) ? ceiling : wval;
          hi_user_next = 1'b1;
        end
        ORT_OFS_MARGIN_LO: begin
          wdat = ort_merge({16'h0000, 16'(lo_eff)}, i_wb_dat, i_wb_sel);
          wval = wdat[V_W-1:0];
          mlo_next = (wdat[31:V_W] != '0 || wval > ceiling) ? ceiling : wval;
          lo_user_next = 1'b1;
        end
        ORT_OFS_TRANS_RATE: begin
          wdat = ort_merge({16'h0000, 16'(rate_reg)}, i_wb_dat, i_wb_sel);
          rate_next = wdat[V_W-1:0];
        end
        ORT_OFS_TRACK_CFG: begin
          wdat = ort_merge({16'h0000, ratio_reg, 4'h0, trk_ratio_mode_reg, trk_ch_reg, trk_en_reg},
                           i_wb_dat, i_wb_sel);
          trk_en_next = wdat[ORT_TRK_EN_BIT];
          trk_ch_next = wdat[ORT_TRK_CH_LSB +: 2];
          trk_ratio_mode_next = wdat[ORT_TRK_MODE_BIT];
          ratio_next = wdat[ORT_TRK_RATIO_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (i_wb_adr)
        ORT_OFS_OPERATION: rdat_next = {30'h00000000, margin_reg};
        ORT_OFS_VOUT_CMD: rdat_next = {15'h0000, vsrc_reg, 16'(vcmd_reg)};
        ORT_OFS_MARGIN_HI: rdat_next = {16'h0000, 16'(hi_eff)};
        ORT_OFS_MARGIN_LO: rdat_next = {16'h0000, 16'(lo_eff)};
        ORT_OFS_TRANS_RATE: rdat_next = {16'h0000, 16'(rate_reg)};
        ORT_OFS_TRACK_CFG: rdat_next = {16'h0000, ratio_reg, 4'h0, trk_ratio_mode_reg, trk_ch_reg, trk_en_reg};
        ORT_OFS_STATUS: rdat_next = {13'h0000, prebias_reg, trk_act_reg, rif.busy, 16'(rif.value)};
        ORT_OFS_NOMINAL: rdat_next = {16'(ceiling), 16'(nominal)};
        default: rdat_next = 32'h00000000;
      endcase
    end
  end

  // Pin values change only once the second and third stages agree
  always_comb begin
    trk_val_next = (trk_s2_reg == trk_s3_reg) ? trk_s3_reg : trk_val_reg;
    strap_val_next = (strap_s2_reg == strap_s3_reg) ? strap_s3_reg : strap_val_reg;
  end

  // Update-period tick for the setpoint ramp
  always_comb begin
    tick_next = (tick_cnt_reg == ($clog2(ORT_UPDATE_CYCLES))'(ORT_UPDATE_CYCLES - 1));
    tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 1'b1;
  end

  // Output references: tracked channels take trk_ref directly, bypassing the soft start
  always_comb begin
    ref0_next = rif.value;
    ref1_next = rif.value;
    if (trk_en_reg && (trk_ch_reg == ORT_TRK_CH0 || trk_ch_reg == ORT_TRK_DUAL)) begin
      ref0_next = trk_ref;
    end
    if (trk_en_reg && (trk_ch_reg == ORT_TRK_CH1 || trk_ch_reg == ORT_TRK_DUAL)) begin
      ref1_next = trk_ref;
    end
    trk_act_next = trk_en_reg && (trk_ch_reg != 2'h3);
    prebias_next = trk_en_reg && (trk_ch_reg == ORT_TRK_DUAL);
  end

  // Register all state; pins sampled through three flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      margin_reg <= ORT_RST_MARGIN;
      vcmd_reg <= V_W'(ORT_RST_VOUT_CMD);
      vsrc_reg <= 1'b0;
      mhi_reg <= '0;
      mlo_reg <= '0;
      hi_user_reg <= 1'b0;
      lo_user_reg <= 1'b0;
      rate_reg <= V_W'(ORT_RST_RATE);
      trk_en_reg <= 1'b0;
      trk_ch_reg <= ORT_TRK_CH0;
      trk_ratio_mode_reg <= 1'b0;
      ratio_reg <= ORT_RST_RATIO;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
      trk_s1_reg <= '0;
      trk_s2_reg <= '0;
      trk_s3_reg <= '0;
      trk_val_reg <= '0;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
      strap_s3_reg <= '0;
      strap_val_reg <= '0;
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
      ref0_reg <= '0;
      ref1_reg <= '0;
      trk_act_reg <= 1'b0;
      prebias_reg <= 1'b0;
    end else begin
      margin_reg <= margin_next;
      vcmd_reg <= vcmd_next;
      vsrc_reg <= vsrc_next;
      mhi_reg <= mhi_next;
      mlo_reg <= mlo_next;
      hi_user_reg <= hi_user_next;
      lo_user_reg <= lo_user_next;
      rate_reg <= rate_next;
      trk_en_reg <= trk_en_next;
      trk_ch_reg <= trk_ch_next;
      trk_ratio_mode_reg <= trk_ratio_mode_next;
      ratio_reg <= ratio_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      trk_s1_reg <= i_tracking_reference_pin;
      trk_s2_reg <= trk_s1_reg;
      trk_s3_reg <= trk_s2_reg;
      trk_val_reg <= trk_val_next;
      strap_s1_reg <= i_setpoint_strap_pin;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      strap_val_reg <= strap_val_next;
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
      ref0_reg <= ref0_next;
      ref1_reg <= ref1_next;
      trk_act_reg <= trk_act_next;
      prebias_reg <= prebias_next;
    end
  end

  // Outputs straight from flops
  always_comb begin
    o_wb_ack = ack_reg;
    o_wb_dat = rdat_reg;
    o_ref_ch0 = ref0_reg;
    o_ref_ch1 = ref1_reg;
    o_tracking_active = trk_act_reg;
    o_ignore_ton_timing = trk_act_reg;
    o_prebias_unprotected = prebias_reg;
  end
endmodule

// *** ort_ref_ctrl_asserts.sv ***
module ort_ref_ctrl_asserts import ort_pkg::*; #(
  parameter int V_W = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [V_W-1:0] i_tracking_reference_pin,
  input wire logic [V_W-1:0] i_setpoint_strap_pin,
  input wire logic [V_W-1:0] o_ref_ch0,
  input wire logic [V_W-1:0] o_ref_ch1,
  input wire logic o_tracking_active,
  input wire logic o_ignore_ton_timing,
  input wire logic o_prebias_unprotected
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic [6:0] cfg_cnt_reg, cfg_cnt_next, trk_cnt_reg, trk_cnt_next, chg_cnt_reg, chg_cnt_next;
  logic [V_W-1:0] ref_prev_reg;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // Request taken at this edge
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;

  // Saturating ages; the ramp check waits after tracking ends, since handing back may jump off-tick
  always_comb begin
    cfg_cnt_next = cfg_cnt_reg + {6'h00, cfg_cnt_reg != 7'h7F};
    if (take && i_wb_we && i_wb_adr == ORT_OFS_TRACK_CFG) cfg_cnt_next = 7'h00;
    trk_cnt_next = o_tracking_active ? 7'h00 : trk_cnt_reg + {6'h00, trk_cnt_reg != 7'h7F};
    if (trk_cnt_reg < 7'h08) chg_cnt_next = 7'h7F;
    else if (o_ref_ch0 != ref_prev_reg) chg_cnt_next = 7'h00;
    else chg_cnt_next = chg_cnt_reg + {6'h00, chg_cnt_reg != 7'h7F};
  end

  // Age registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_cnt_reg <= 7'h7F;
      trk_cnt_reg <= 7'h7F;
      chg_cnt_reg <= 7'h7F;
      ref_prev_reg <= '0;
    end else begin
      cfg_cnt_reg <= cfg_cnt_next;
      trk_cnt_reg <= trk_cnt_next;
      chg_cnt_reg <= chg_cnt_next;
      ref_prev_reg <= o_ref_ch0;
    end
  end

  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held over one cycle");
  a_ack_answer: assert property (take |=> o_wb_ack) else $error("request not answered next cycle");
  a_unmapped_zero: assert property (take && !i_wb_we && i_wb_adr > ORT_OFS_NOMINAL |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property ($changed(o_wb_dat) |-> o_wb_ack) else $error("read data moved without ack");
  a_ton_skip: assert property (o_ignore_ton_timing == o_tracking_active)
    else $error("turn-on skip differs from tracking");
  a_prebias_flag: assert property (o_prebias_unprotected |-> o_tracking_active)
    else $error("prebias flag without tracking");
  a_track_cause: assert property ($changed(o_tracking_active) |-> cfg_cnt_reg <= 7'h08)
    else $error("tracking changed without setup write");
  a_ramp_period: assert property (o_ref_ch0 != ref_prev_reg && trk_cnt_reg >= 7'h08
    |-> chg_cnt_reg >= 7'(ORT_UPDATE_CYCLES - 1)) else $error("setpoint stepped off the update period");

  c_write: cover property (take && i_wb_we);
  c_track: cover property ($rose(o_tracking_active));
  c_prebias: cover property ($rose(o_prebias_unprotected));
endmodule

bind ort_ref_ctrl ort_ref_ctrl_asserts #(.V_W(V_W)) u_asserts (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_tracking_reference_pin(i_tracking_reference_pin), .i_setpoint_strap_pin(i_setpoint_strap_pin),
  .o_ref_ch0(o_ref_ch0), .o_ref_ch1(o_ref_ch1), .o_tracking_active(o_tracking_active),
  .o_ignore_ton_timing(o_ignore_ton_timing), .o_prebias_unprotected(o_prebias_unprotected));

// *** ort_trk_master.sv ***
module ort_trk_master #(
  parameter int V_W = 16,
  parameter logic [V_W-1:0] STEP = 16'h0010
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [V_W-1:0] i_goal,
  output logic [V_W-1:0] o_pin,
  output logic o_settled
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [V_W-1:0] pin_reg, pin_next;

  // The master sets the group ramp and never tracks; slew capped at STEP per cycle
  always_comb begin
    if (i_goal > pin_reg + STEP) pin_next = pin_reg + STEP;
    else if (pin_reg > i_goal + STEP) pin_next = pin_reg - STEP;
    else pin_next = i_goal;
  end

  // Reference register, starts from zero
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) pin_reg <= '0;
    else pin_reg <= pin_next;
  end

  assign o_pin = pin_reg;
  assign o_settled = (pin_reg == i_goal);
endmodule

// *** test_output_reference_tracking_margin.sv ***
module test_output_reference_tracking_margin import ort_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk;
  logic i_nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, q;
  logic [15:0] strap = 16'h1000; // Steady-state target of this slave
  logic [15:0] goal = 16'h0000;
  logic [31:0] rdat;
  logic ack, trk, ign, pb, settled;
  logic [15:0] pin, ref0, ref1;
  logic [1:0] ops [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic [15:0] exps [4] = '{16'h0000, 16'h1199, 16'h1000, 16'h1000};
  int n_mismatch = 0, n_tests = 0;

  ort_trk_master #(.V_W(16), .STEP(16'h0010)) master (.i_clk(i_clk), .i_nrst(i_nrst), .i_goal(goal),
    .o_pin(pin), .o_settled(settled));
  ort_ref_ctrl #(.V_W(16)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_tracking_reference_pin(pin), .i_setpoint_strap_pin(strap), .o_ref_ch0(ref0), .o_ref_ch1(ref1),
    .o_tracking_active(trk), .o_ignore_ton_timing(ign), .o_prebias_unprotected(pb));

  // Free-running 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wait_change();
    logic [15:0] v = ref0;
    int n = 0;
    while (ref0 === v && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 300) n_mismatch++;
  endtask

  // Master moves only after the slave is set up
  task automatic move(input logic [15:0] g);
    int n = 0;
    @(posedge i_clk);
    goal <= g;
    do begin
      @(negedge i_clk);
      n++;
    end while (settled !== 1'b1 && n < 2000);
    if (n >= 2000) n_mismatch++;
    tick(12);
  endtask

  // Hang guard, well beyond the roughly 6k cycles of the sequence
  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    rdc(ORT_OFS_OPERATION, 32'h0);
    rdc(ORT_OFS_TRACK_CFG, 32'h8000);
    rdc(ORT_OFS_NOMINAL, 32'h1199_1000);
    rdc(ORT_OFS_MARGIN_HI, 32'h10CC);
    rdc(ORT_OFS_MARGIN_LO, 32'h0F33);
    rdc(ORT_OFS_TRANS_RATE, 32'h1);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0);
    wb(1'b1, ORT_OFS_NOMINAL, 32'h0);
    rdc(ORT_OFS_NOMINAL, 32'h1199_1000);
    // Settle on nominal, then slew to margin high in small steps
    wb(1'b1, ORT_OFS_TRANS_RATE, 32'h400);
    tick(700);
    chk(ref0, 32'h1000);
    wb(1'b1, ORT_OFS_TRANS_RATE, 32'h40);
    wb(1'b1, ORT_OFS_OPERATION, {30'h0, ORT_MARGIN_HIGH});
    wait_change();
    chk(ref0, 32'h1040);
    tick(400);
    chk(ref0, 32'h10CC);
    wb(1'b1, ORT_OFS_MARGIN_HI, 32'hFFFF);
    rdc(ORT_OFS_MARGIN_HI, 32'h1199);
    wb(1'b1, ORT_OFS_MARGIN_LO, 32'h0);
    rdc(ORT_OFS_MARGIN_LO, 32'h0);
    wb(1'b1, ORT_OFS_TRANS_RATE, 32'h400);
    // Every margin code, including the spare one
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ORT_OFS_OPERATION, {30'h0, ops[i]});
      rdc(ORT_OFS_OPERATION, {30'h0, ops[i]});
      tick(700);
      chk(ref0, exps[i]);
    end
    // Coincident on channel 0, up past target and back down
    wb(1'b1, ORT_OFS_TRACK_CFG, 32'h8001);
    tick(10);
    chk(trk, 1'b1);
    chk(ign, 1'b1);
    move(16'h0800);
    chk(ref0, 32'h0800);
    move(16'h2000);
    chk(ref0, 32'h1000);
    move(16'h0300);
    chk(ref0, 32'h0300);
    move(16'h0800);
    // Ratiometric on channel 1 at the default and a custom ratio
    wb(1'b1, ORT_OFS_TRACK_CFG, 32'h800B);
    tick(12);
    chk(ref1, 32'h0400);
    wb(1'b1, ORT_OFS_TRACK_CFG, 32'h400B);
    tick(12);
    chk(ref1, 32'h0200);
    wb(1'b1, ORT_OFS_TRACK_CFG, 32'h8005);
    tick(10);
    chk(pb, 1'b1);
    rdc(ORT_OFS_STATUS, 32'h0006_1000);
    wb(1'b1, ORT_OFS_TRACK_CFG, 32'h8007);
    tick(10);
    chk(trk, 1'b0);
    wb(1'b1, ORT_OFS_TRACK_CFG, 32'h0);
    tick(10);
    chk(ign, 1'b0);
    // Nominal from the command word; the stored high limit is clamped to the new ceiling
    wb(1'b1, ORT_OFS_VOUT_CMD, 32'h0001_0800);
    rdc(ORT_OFS_VOUT_CMD, 32'h0001_0800);
    rdc(ORT_OFS_NOMINAL, 32'h08CC_0800);
    rdc(ORT_OFS_MARGIN_HI, 32'h08CC);
    tick(700);
    chk(ref0, 32'h0800);
    complete_run();
  end
endmodule
